/* cto_regs.svh */
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the output control block and its package users
`ifndef CTO_REGS_SVH
`define CTO_REGS_SVH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CTO_OFS_GEN_CFG 8'h02
`define CTO_OFS_PLL_CTL 8'h1f
`define CTO_OFS_FWD_ONE 8'h20
`define CTO_OFS_FWD_TWO 8'h21
`define CTO_OFS_TX_STS 8'h35
`define CTO_OFS_VC_MAP0 8'h78
`define CTO_OFS_VC_MAP1 8'h79
`define CTO_OFS_LCNT_HI 8'h73
`define CTO_OFS_LCNT_LO 8'h74
`define CTO_OFS_LLEN_HI 8'h75
`define CTO_OFS_LLEN_LO 8'h76
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTO_GEN_DRV 0
`define CTO_GEN_SLEEP 1
`define CTO_GEN_IDLE_MODE 2
`define CTO_PLL_OVR 7
`define CTO_FWD1_OFF0 4
`define CTO_FWD1_OFF1 5
`define CTO_FWD2_SYNC 0
`define CTO_FWD2_REPL 7
`define CTO_STS_PASS 0
`define CTO_STS_SYNC 1
`define CTO_STS_TFLT 2
// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define CTO_RST_GEN_CFG 8'h03
`define CTO_RST_PLL_CTL 8'h00
`define CTO_RST_FWD 8'h00
`define CTO_RST_VC_MAP0 8'he4
`define CTO_RST_VC_MAP1 8'he4
`define CTO_CLK_MHZ 100
`define CTO_BC_FRAME_NS 600
`define CTO_BC_TICK_CYC ((`CTO_BC_FRAME_NS * `CTO_CLK_MHZ) / 1000)
`define CTO_FIFO_DEPTH 32
`define CTO_REF_MHZ 25
`endif

/* cto_pkg.sv */
// Types shared by the output control block
// Assumes the constants header is compiled alongside
package cto_pkg;
  // Transmitter pin state
  typedef enum logic [1:0] {CTO_HIZ, CTO_HS0, CTO_LP11, CTO_VALID} cto_pin_t;
  // Forwarding engine state
  typedef enum logic {CTO_IDLE, CTO_SEND} cto_fwd_t;
  typedef logic [11:0] cto_word_t;
endpackage : cto_pkg

/* cto_output_ctrl.sv */
// Camera-link hub output control: remap, rate select, replicate,
// pin state, status, packet buffers and line statistics
// Assumes a byte-wide receive link timed by link_clk_i from another
// domain, a same-clock downstream consumer and a simple register port
`timescale 1ns/1ps
`include "cto_regs.svh"

// ----------------------------------------------------------------------
// Packet FIFO
// ----------------------------------------------------------------------
module cto_fifo #(
  parameter int W = 12,
  parameter int D = 32
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  // Handshake terms
  assign in_ready_o = (cnt_r != (AW+1)'(D));
  assign out_valid_o = (cnt_r != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_r[rp_r];

  // Storage write
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end

  // Pointers and fill level
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : cto_fifo

// ----------------------------------------------------------------------
// Output control top
// ----------------------------------------------------------------------
module cto_output_ctrl #(
  parameter int REF_MHZ = `CTO_REF_MHZ
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic power_down_pin_i,
  input wire logic link_clk_i,
  input wire logic [1:0] rx_lock_i,
  input wire logic [1:0] rx_err_i,
  input wire logic [1:0] rx_valid_i,
  input wire logic [1:0] rx_last_i,
  input wire logic [1:0] rx_long_i,
  input wire logic [1:0][1:0] rx_vc_i,
  input wire logic [1:0][7:0] rx_data_i,
  output logic [1:0] rx_ready_o,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output cto_pkg::cto_pin_t tx0_state_o,
  output cto_pkg::cto_pin_t tx1_state_o,
  output logic tx0_oe_o,
  output logic tx1_oe_o,
  output logic tx1_clk_en_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output logic [7:0] tx0_data_o,
  output logic [1:0] tx0_vc_o,
  output logic tx0_last_o,
  output logic [7:0] tx1_data_o,
  output logic [1:0] tx1_vc_o,
  output logic tx1_last_o,
  output logic [11:0] lane_rate_mbps_o,
  output logic timing_auto_o,
  output logic bc_tick_o,
  output logic status_gpio_o,
  output logic status_chg_o
);
  import cto_pkg::*;

  // Multiplier of the reference clock for each rate code
  function automatic logic [6:0] rate_mult(input logic [1:0] sel);
    case (sel)
      2'b00: rate_mult = 7'h40;
      2'b10: rate_mult = 7'h20;
      2'b11: rate_mult = 7'h10;
      default: rate_mult = 7'h00;
    endcase
  endfunction : rate_mult

  logic [7:0] gen_r, pll_r, fwd1_r, fwd2_r, map0_r, map1_r;
  logic [1:0] s1_clk_r, s2_clk_r, s3_clk_r;
  logic pwr_s1_r, pwr_s2_r;
  logic [1:0] lock_s1_r, lock_s2_r, err_s1_r, err_s2_r;
  logic [1:0][12:0] rx_s1_r, rx_s2_r;
  logic link_rise;
  cto_pin_t pin_nxt, pin_r;
  logic [1:0] push;
  logic [1:0] in_rdy;
  logic [1:0] f_valid;
  logic [1:0] f_pop;
  cto_word_t [1:0] f_in;
  cto_word_t [1:0] f_out;
  logic [1:0][5:0] pkt_cnt_r;
  cto_fwd_t fwd_r;
  logic cur_r;
  logic ovf_r;
  logic pass_r, sync_r, tflt_r;
  logic [2:0] sts_d_r;
  logic [15:0] lcnt_r, llen_r, bcnt_r;
  logic [7:0] tick_r;
  logic out_load;
  logic repl;

  assign repl = fwd2_r[`CTO_FWD2_REPL];

  // Register writes
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      gen_r <= `CTO_RST_GEN_CFG;
      pll_r <= `CTO_RST_PLL_CTL;
      fwd1_r <= `CTO_RST_FWD;
      fwd2_r <= `CTO_RST_FWD;
      map0_r <= `CTO_RST_VC_MAP0;
      map1_r <= `CTO_RST_VC_MAP1;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `CTO_OFS_GEN_CFG: gen_r <= reg_wdata_i;
        `CTO_OFS_PLL_CTL: pll_r <= reg_wdata_i;
        `CTO_OFS_FWD_ONE: fwd1_r <= reg_wdata_i;
        `CTO_OFS_FWD_TWO: fwd2_r <= reg_wdata_i;
        `CTO_OFS_VC_MAP0: map0_r <= reg_wdata_i;
        `CTO_OFS_VC_MAP1: map1_r <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // Register reads, unmapped offsets read zero
  always_comb begin
    case (reg_addr_i)
      `CTO_OFS_GEN_CFG: reg_rdata_o = gen_r;
      `CTO_OFS_PLL_CTL: reg_rdata_o = pll_r;
      `CTO_OFS_FWD_ONE: reg_rdata_o = fwd1_r;
      `CTO_OFS_FWD_TWO: reg_rdata_o = fwd2_r;
      `CTO_OFS_VC_MAP0: reg_rdata_o = map0_r;
      `CTO_OFS_VC_MAP1: reg_rdata_o = map1_r;
      `CTO_OFS_TX_STS: reg_rdata_o = {5'h00, tflt_r, sync_r, pass_r};
      `CTO_OFS_LCNT_HI: reg_rdata_o = lcnt_r[15:8];
      `CTO_OFS_LCNT_LO: reg_rdata_o = lcnt_r[7:0];
      `CTO_OFS_LLEN_HI: reg_rdata_o = llen_r[15:8];
      `CTO_OFS_LLEN_LO: reg_rdata_o = llen_r[7:0];
      default: reg_rdata_o = 8'h00;
    endcase
  end

  // Rate selection; lane rate follows the reference frequency
  assign lane_rate_mbps_o = 12'(rate_mult(pll_r[1:0]) * REF_MHZ);
  assign timing_auto_o = (pll_r[1:0] == 2'b00) || (pll_r[1:0] == 2'b10);

  // Back channel frame tick every CTO_BC_TICK_CYC reference cycles, a count fixed by CTO_CLK_MHZ, not by REF_MHZ
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tick_r <= 8'h00;
      bc_tick_o <= 1'b0;
    end else begin
      bc_tick_o <= (tick_r == 8'(`CTO_BC_TICK_CYC - 1));
      tick_r <= (tick_r == 8'(`CTO_BC_TICK_CYC - 1)) ? 8'h00 : tick_r + 8'h01;
    end
  end

  // Pin and link synchronisers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s1_clk_r <= 2'b00;
      s2_clk_r <= 2'b00;
      s3_clk_r <= 2'b00;
      pwr_s1_r <= 1'b0;
      pwr_s2_r <= 1'b0;
      lock_s1_r <= 2'b00;
      lock_s2_r <= 2'b00;
      err_s1_r <= 2'b00;
      err_s2_r <= 2'b00;
      rx_s1_r <= '0;
      rx_s2_r <= '0;
    end else begin
      s1_clk_r <= {1'b0, link_clk_i};
      s2_clk_r <= s1_clk_r;
      s3_clk_r <= s2_clk_r;
      pwr_s1_r <= power_down_pin_i;
      pwr_s2_r <= pwr_s1_r;
      lock_s1_r <= rx_lock_i;
      lock_s2_r <= lock_s1_r;
      err_s1_r <= rx_err_i;
      err_s2_r <= err_s1_r;
      for (int p = 0; p < 2; p++) begin
        rx_s1_r[p] <= {rx_valid_i[p], rx_long_i[p], rx_last_i[p], rx_vc_i[p], rx_data_i[p]};
      end
      rx_s2_r <= rx_s1_r;
    end
  end
  assign link_rise = s2_clk_r[0] && !s3_clk_r[0];

  // Buffer fill: remap the channel ID, one FIFO per receive port
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      push[p] = link_rise && rx_s2_r[p][12];
      f_in[p] = {rx_s2_r[p][11:10], (p == 0) ? map0_r[2*rx_s2_r[p][9:8] +: 2]
                : map1_r[2*rx_s2_r[p][9:8] +: 2], rx_s2_r[p][7:0]};
    end
  end
  assign rx_ready_o = in_rdy;

  for (genvar g = 0; g < 2; g++) begin : g_buf
    cto_fifo #(.W(12), .D(`CTO_FIFO_DEPTH)) u_fifo (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .in_valid_i(push[g]),
      .in_ready_o(in_rdy[g]),
      .in_data_i(f_in[g]),
      .out_valid_o(f_valid[g]),
      .out_ready_i(f_pop[g]),
      .out_data_o(f_out[g])
    );
  end

  // Whole packets held per buffer
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pkt_cnt_r <= '0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        pkt_cnt_r[p] <= pkt_cnt_r[p] + 6'(push[p] && in_rdy[p] && f_in[p][10])
                        - 6'(f_pop[p] && f_out[p][10]);
      end
    end
  end

  // Output pin state from power-down, controls, lock and forwarding
  always_comb begin
    if (!pwr_s2_r) begin
      pin_nxt = CTO_HIZ;
    end else if (!gen_r[`CTO_GEN_SLEEP]) begin
      pin_nxt = CTO_HS0;
    end else if (!gen_r[`CTO_GEN_DRV]) begin
      pin_nxt = CTO_HIZ;
    end else if (lock_s2_r == 2'b00) begin
      pin_nxt = gen_r[`CTO_GEN_IDLE_MODE] ? CTO_LP11 : CTO_HIZ;
    end else if (fwd1_r[`CTO_FWD1_OFF0] && fwd1_r[`CTO_FWD1_OFF1]) begin
      pin_nxt = CTO_LP11;
    end else begin
      pin_nxt = CTO_VALID;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pin_r <= CTO_HIZ;
    end else begin
      pin_r <= pin_nxt;
    end
  end
  assign tx0_state_o = pin_r;
  assign tx0_oe_o = (pin_r != CTO_HIZ);
  assign tx1_state_o = repl ? pin_r : CTO_HIZ;
  assign tx1_oe_o = repl && (pin_r != CTO_HIZ);
  assign tx1_clk_en_o = repl;

  // Forwarding engine: alternate ports on packet boundaries
  assign out_load = !tx_valid_o || tx_ready_i;
  always_comb begin
    f_pop = 2'b00;
    if (fwd_r == CTO_SEND && out_load && f_valid[cur_r]) begin
      f_pop[cur_r] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      fwd_r <= CTO_IDLE;
      cur_r <= 1'b0;
    end else begin
      case (fwd_r)
        CTO_IDLE: begin
          if (pin_r == CTO_VALID) begin
            if (pkt_cnt_r[!cur_r] != 6'h00 && !fwd1_r[`CTO_FWD1_OFF0 + 32'(!cur_r)]) begin
              cur_r <= !cur_r;
              fwd_r <= CTO_SEND;
            end else if (pkt_cnt_r[cur_r] != 6'h00 && !fwd1_r[`CTO_FWD1_OFF0 + 32'(cur_r)]) begin
              fwd_r <= CTO_SEND;
            end
          end
        end
        CTO_SEND: begin
          if (f_pop[cur_r] && f_out[cur_r][10]) fwd_r <= CTO_IDLE;
        end
        default: fwd_r <= CTO_IDLE;
      endcase
    end
  end

  // Output word registers; port 1 copies port 0 in replicate mode
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_valid_o <= 1'b0;
      tx0_data_o <= 8'h00;
      tx0_vc_o <= 2'b00;
      tx0_last_o <= 1'b0;
      tx1_data_o <= 8'h00;
      tx1_vc_o <= 2'b00;
      tx1_last_o <= 1'b0;
    end else if (out_load) begin
      tx_valid_o <= |f_pop;
      tx0_data_o <= f_out[cur_r][7:0];
      tx0_vc_o <= f_out[cur_r][9:8];
      tx0_last_o <= f_out[cur_r][10];
      tx1_data_o <= repl ? f_out[cur_r][7:0] : 8'h00;
      tx1_vc_o <= repl ? f_out[cur_r][9:8] : 2'b00;
      tx1_last_o <= repl && f_out[cur_r][10];
    end
  end

  // Status bits, change event and general output pin
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ovf_r <= 1'b0;
      pass_r <= 1'b0;
      sync_r <= 1'b0;
      tflt_r <= 1'b0;
      sts_d_r <= 3'h0;
      status_chg_o <= 1'b0;
    end else begin
      ovf_r <= |(push & ~in_rdy);
      pass_r <= (pin_r == CTO_VALID) && (fwd_r == CTO_SEND) && !(|err_s2_r)
                && !ovf_r;
      sync_r <= fwd2_r[`CTO_FWD2_SYNC] && (lock_s2_r == 2'b11);
      tflt_r <= !timing_auto_o && !pll_r[`CTO_PLL_OVR];
      sts_d_r <= {tflt_r, sync_r, pass_r};
      status_chg_o <= (sts_d_r != {tflt_r, sync_r, pass_r});
    end
  end
  assign status_gpio_o = pass_r;

  // Line statistics on receive port 0, exact for a single stream only
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      bcnt_r <= 16'h0000;
      lcnt_r <= 16'h0000;
      llen_r <= 16'h0000;
    end else if (push[0] && f_in[0][11]) begin
      if (f_in[0][10]) begin
        bcnt_r <= 16'h0000;
        lcnt_r <= lcnt_r + 16'h0001;
        llen_r <= bcnt_r + 16'h0001;
      end else begin
        bcnt_r <= bcnt_r + 16'h0001;
      end
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_hs0_forced: assert property (pwr_s2_r && !gen_r[`CTO_GEN_SLEEP] |=> tx0_state_o == CTO_HS0)
    else $error("sleep choice 0 did not force HS-0");
  a_pwr_low_hiz: assert property (!pwr_s2_r |=> !tx0_oe_o && tx0_state_o == CTO_HIZ)
    else $error("power-down low did not give high impedance");
  a_drv_off_hiz: assert property (pwr_s2_r && gen_r[1:0] == 2'b10 |=> tx0_state_o == CTO_HIZ)
    else $error("drive enable 0 did not give high impedance");
  a_idle_state: assert property (pwr_s2_r && gen_r[1:0] == 2'b11 && lock_s2_r == 2'b00
      |=> tx0_state_o == ($past(gen_r[2]) ? CTO_LP11 : CTO_HIZ))
    else $error("idle pin state wrong");
  a_fwd_off_lp11: assert property (pwr_s2_r && gen_r[1:0] == 2'b11 && fwd1_r[5:4] == 2'b11
      |=> tx0_state_o inside {CTO_LP11, CTO_HIZ})
    else $error("forwarding off did not stop data");
  a_pass_clear: assert property (tx0_state_o != CTO_VALID || (|err_s2_r) |=> !pass_r)
    else $error("pass bit stayed set");
  a_sync_zero: assert property (!fwd2_r[`CTO_FWD2_SYNC] |=> !sync_r)
    else $error("sync bit set while sync forwarding off");
  a_repl_clock: assert property (repl |-> tx1_clk_en_o && tx1_state_o == tx0_state_o)
    else $error("replicate did not enable second clock lane");
  a_repl_copy: assert property (repl && out_load |=> tx1_data_o == tx0_data_o
      && tx1_last_o == tx0_last_o)
    else $error("port 1 differs from port 0 in replicate");
  a_whole_packet: assert property ($rose(fwd_r == CTO_SEND)
      |-> (cur_r ? $past(pkt_cnt_r[1]) : $past(pkt_cnt_r[0])) != 6'h00)
    else $error("packet pulled before complete");
  a_vc_remap: assert property (push[1] |-> f_in[1][9:8] == map1_r[2*rx_s2_r[1][9:8] +: 2])
    else $error("channel ID not remapped");
  a_rate_scale: assert property (pll_r[1:0] == 2'b10 |-> lane_rate_mbps_o == 12'(32 * REF_MHZ))
    else $error("lane rate not scaled");
  a_line_count: assert property (push[0] && f_in[0][11] && f_in[0][10]
      |=> lcnt_r == $past(lcnt_r) + 16'h0001)
    else $error("line count not advanced");

  c_valid_out: cover property (tx0_state_o == CTO_VALID && tx_valid_o && tx_ready_i);
  c_packet_done: cover property (tx_valid_o && tx0_last_o && tx_ready_i);
  c_replicate: cover property (repl && tx_valid_o);
  c_port_switch: cover property ($changed(cur_r) && fwd_r == CTO_SEND);
endmodule : cto_output_ctrl

/* cto_sink.sv */
// Downstream video processor model taking the transmit byte stream
// Assumes the block's clock and a stall request from the bench
`timescale 1ns/1ps
module cto_sink (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic stall_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [31:0] beats_o
);
  // Ready moves only just after an edge, so a stall never cuts a byte in half
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_ready_o <= 1'b0;
    end else begin
      tx_ready_o <= !stall_i;
    end
  end
  // Accepted byte count, handy when looking at waves
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      beats_o <= 32'h0000_0000;
    end else if (tx_valid_i && tx_ready_o) begin
      beats_o <= beats_o + 32'h0000_0001;
    end
  end
endmodule : cto_sink

/* cto_output_ctrl_bench.sv */
// Self-checking bench for the output control block
// Assumes the design files, the constants header and the sink model
`timescale 1ns/1ps
`include "cto_regs.svh"
module cto_output_ctrl_bench;
  import cto_pkg::*;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
  localparam int REF = 26;
  logic ref_clk_i = 0, rst_i = 1, pd = 1, link_clk = 0, link_run = 0, wr = 0;
  logic [1:0] lock = 0, err = 0, rv = 0, rl = 0, rlong = 0, rrdy;
  logic [1:0][1:0] rvc = '0;
  logic [1:0][7:0] rd = '0;
  logic [7:0] addr = 0, wd = 0, rdata, d0, d1;
  cto_pin_t s0, s1;
  logic oe0, oe1, ck1, tv, trdy, l0, l1, auto, tick, gpio, chg, stall = 1;
  logic [1:0] v0, v1;
  logic [11:0] rate;
  logic repl = 0, nocmp = 0, hold_stall = 0, pass_seen = 0, full_seen = 0;
  logic [10:0] expq[$], xq;
  int fail_count = 0, comparisons = 0, nchg = 0, n, mult[4] = '{64, 0, 32, 16};
  logic [9:0] e, pins[8] = '{10'h184, 10'h205, 10'h304, 10'h380, 10'h3c2, 10'h3b6,
    10'h38b, 10'h3c7};
  // Clocks: link clock only runs inside frames
  always #5 ref_clk_i = ~ref_clk_i;
  always #62.5 link_clk = link_run ? ~link_clk : 1'b0;
  always @(posedge ref_clk_i) stall <= hold_stall | ($urandom % 4 == 0);
  cto_output_ctrl #(.REF_MHZ(REF)) uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .power_down_pin_i(pd), .link_clk_i(link_clk), .rx_lock_i(lock), .rx_err_i(err),
    .rx_valid_i(rv), .rx_last_i(rl), .rx_long_i(rlong), .rx_vc_i(rvc), .rx_data_i(rd),
    .rx_ready_o(rrdy), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wd),
    .reg_rdata_o(rdata), .tx0_state_o(s0), .tx1_state_o(s1), .tx0_oe_o(oe0),
    .tx1_oe_o(oe1), .tx1_clk_en_o(ck1), .tx_valid_o(tv), .tx_ready_i(trdy),
    .tx0_data_o(d0), .tx0_vc_o(v0), .tx0_last_o(l0), .tx1_data_o(d1), .tx1_vc_o(v1),
    .tx1_last_o(l1), .lane_rate_mbps_o(rate), .timing_auto_o(auto), .bc_tick_o(tick),
    .status_gpio_o(gpio), .status_chg_o(chg));
  cto_sink partner (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .stall_i(stall),
    .tx_valid_i(tv), .tx_ready_o(trdy), .beats_o());
  // Output monitor compares every accepted byte with the model queue while nocmp is clear
  always @(posedge ref_clk_i) begin
    if (chg) nchg++;
    if (rrdy[0] === 1'b0) full_seen = 1;
    if (!rst_i && tv && trdy && !nocmp) begin
      if (gpio) pass_seen = 1;
      xq = expq.size() ? expq.pop_front() : 11'h7ff;
      `CHK({v0, d0, l0}, xq)
      if (repl) `CHK({v1, d1, l1}, xq)
      else `CHK({v1, d1, l1}, 11'h000)
    end
  end
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic cyc;
    @(posedge ref_clk_i);
    #1;
  endtask : cyc
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask : wreg
  task automatic rchk(input logic [7:0] a, input logic [7:0] x);
    @(posedge ref_clk_i);
    addr <= a;
    #1;
    `CHK(rdata, x)
  endtask : rchk
  // One packet, long when lng is set; hold stops the link before the last byte
  task automatic pkt(input int p, input int len, input logic [1:0] vc,
      input logic [1:0] ovc, input int hold, input logic lng);
    logic [7:0] d;
    int seen = 0;
    link_run = 1'b1;
    for (int i = 0; i < len; i++) begin
      d = 8'($urandom);
      if (i == len - 1 && hold > 0) begin
        // Drop valid before the clock stops, so the restart edge takes nothing
        @(negedge link_clk);
        @(posedge ref_clk_i);
        rv[p] <= 1'b0;
        link_run = 1'b0;
        repeat (hold) begin
          cyc();
          if (tv) seen++;
        end
        `CHK(seen, 0)
        link_run = 1'b1;
      end
      expq.push_back({ovc, d, i == len - 1});
      @(negedge link_clk);
      @(posedge ref_clk_i);
      rv[p] <= 1'b1;
      rd[p] <= d;
      rvc[p] <= vc;
      rl[p] <= (i == len - 1);
      rlong[p] <= lng;
      @(posedge link_clk);
    end
    @(negedge link_clk);
    @(posedge ref_clk_i);
    rv[p] <= 1'b0;
    rd[p] <= ~rd[p];
    link_run = 1'b0;
  endtask : pkt
  task automatic drain;
    for (int i = 0; i < 4000 && expq.size() > 0; i++) cyc();
    if (expq.size() > 0) begin
      fail_count++;
      final_report();
    end
  endtask : drain
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  initial begin
    #900us;
    fail_count++;
    final_report();
  end
  // Main sequence
  initial begin
    void'($urandom(87204));
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rchk(`CTO_OFS_GEN_CFG, 8'h03);
    rchk(`CTO_OFS_VC_MAP1, 8'he4);
    wreg(`CTO_OFS_TX_STS, 8'hff);
    rchk(`CTO_OFS_TX_STS, 8'h00);
    rchk(8'h10, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wreg(`CTO_OFS_PLL_CTL, 8'(c));
      rchk(`CTO_OFS_PLL_CTL, 8'(c));
      `CHK(rate, 12'(mult[c] * REF))
      `CHK(auto, logic'(c == 0 || c == 2))
      if (c != 1) rchk(`CTO_OFS_TX_STS, {5'h00, logic'(c == 3), 2'b00});
    end
    wreg(`CTO_OFS_PLL_CTL, 8'h83);
    rchk(`CTO_OFS_TX_STS, 8'h00);
    wreg(`CTO_OFS_PLL_CTL, 8'h00);
    $display("Test registers and rate done");
    for (int k = 0; k < 8; k++) begin
      e = pins[k];
      pd <= e[9];
      lock <= e[3:2];
      wreg(`CTO_OFS_GEN_CFG, {5'h00, e[6], e[8], e[7]});
      wreg(`CTO_OFS_FWD_ONE, {2'b00, e[4], e[5], 4'h0});
      repeat (6) cyc();
      `CHK(s0, cto_pin_t'(e[1:0]))
      `CHK(oe0, e[1:0] != 2'd0)
    end
    $display("Test pin states done");
    wreg(`CTO_OFS_GEN_CFG, 8'h03);
    lock <= 2'b11;
    repeat (6) cyc();
    rchk(`CTO_OFS_TX_STS, 8'h00);
    n = nchg;
    wreg(`CTO_OFS_FWD_TWO, 8'h01);
    repeat (6) cyc();
    rchk(`CTO_OFS_TX_STS, 8'h02);
    `CHK(nchg > n, 1'b1)
    wreg(`CTO_OFS_FWD_TWO, 8'h00);
    $display("Test sync status done");
    wreg(`CTO_OFS_VC_MAP1, 8'hee);
    for (int k = 0; k < 4; k++) pkt(1, 2 + $urandom % 5, 2'(k % 2), 2'(k % 2 + 2),
      k == 0 ? 60 : 0, 1'b1);
    drain();
    // Lane count is taken as one or two before replicate is set
    wreg(`CTO_OFS_FWD_TWO, 8'h80);
    repl = 1;
    repeat (2) cyc();
    `CHK(ck1, 1'b1)
    `CHK(s1, s0)
    for (int k = 0; k < 3; k++) begin
      n = 2 + $urandom % 6;
      pkt(0, n, 2'(k), 2'(k), 0, 1'b1);
    end
    // A short packet is forwarded but leaves the line statistics alone
    pkt(0, 3, 2'b01, 2'b01, 0, 1'b0);
    drain();
    `CHK(pass_seen, 1'b1)
    rchk(`CTO_OFS_LCNT_HI, 8'h00);
    rchk(`CTO_OFS_LCNT_LO, 8'h03);
    rchk(`CTO_OFS_LLEN_HI, 8'h00);
    rchk(`CTO_OFS_LLEN_LO, 8'(n));
    $display("Test streams done");
    // Hold a packet mid-flight so pass is up, then flag a data error
    hold_stall = 1;
    pkt(0, 4, 2'b00, 2'b00, 0, 1'b1);
    for (int i = 0; i < 200 && !tv; i++) cyc();
    repeat (4) cyc();
    `CHK(gpio, 1'b1)
    @(posedge ref_clk_i) err <= 2'b01;
    repeat (6) cyc();
    `CHK(gpio, 1'b0)
    @(posedge ref_clk_i) err <= 2'b00;
    hold_stall = 0;
    drain();
    for (int i = 0; i < 200 && !tick; i++) cyc();
    cyc();
    n = 1;
    while (!tick && n < 200) begin
      cyc();
      n++;
    end
    `CHK(n, `CTO_BC_TICK_CYC)
    $display("Test status and tick done");
    hold_stall = 1;
    nocmp = 1;
    for (int k = 0; k < 12; k++) pkt(0, 4, 2'b00, 2'b00, 0, 1'b1);
    hold_stall = 0;
    repeat (800) cyc();
    `CHK(full_seen, 1'b1)
    `CHK(rrdy[0], 1'b1)
    $display("Test buffer fill done");
    final_report();
  end
endmodule : cto_output_ctrl_bench
